// ### rtl/seq_engine_pkg.sv
// Types shared by the sequencing engine files
package seq_engine_pkg;
	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_FETCH = 2'b01,
		PH_RUN = 2'b10
	} phase_t;

	typedef enum logic [1:0] {
		SRC_ENGINE = 2'b00,
		SRC_HOST = 2'b01,
		SRC_CLOCK = 2'b10
	} drv_src_t;

	typedef enum logic [1:0] {
		RESP_OKAY = 2'b00,
		RESP_SLVERR = 2'b10
	} axi_resp_t;

	typedef logic [5:0] state_idx_t;
endpackage

// ### rtl/seq_engine_regs.svh
// Register offsets, field positions, reset values and timing counts of the sequencing engine
`ifndef SEQ_ENGINE_REGS_SVH
`define SEQ_ENGINE_REGS_SVH

// Byte offsets on the register bus
`define OFS_CTRL 8'h00
`define OFS_ENG_STATUS 8'h04
`define OFS_JUMP 8'h08
`define OFS_TBL_INDEX 8'h0C
`define OFS_TBL_W0 8'h10
`define OFS_TBL_W1 8'h14
`define OFS_TBL_W2 8'h18
`define OFS_FAULT_LO 8'h1C
`define OFS_FAULT_HI 8'h20
`define OFS_LIVE_UVOV 8'h24
`define OFS_LIVE_WARN 8'h28
`define OFS_DRV_SRC 8'h2C
`define OFS_DRV_HOST 8'h30

// Table geometry
`define NUM_STATES 63
`define NUM_WORDS 3
`define TBL_DEPTH 189
`define NUM_INPUTS 10
`define NUM_ENG_IN 11

// Table word 0 fields
`define W0_SEQ_NEXT 0
`define W0_MON_NEXT 8
`define W0_TMO_NEXT 16
`define W0_LATCH_EN 24
`define W0_SEQ_POL 25
`define W0_SEQ_SEL 28
`define SEQ_SEL_JUMP_ONLY 4'hF
// Table word 1 fields
`define W1_OUT 0
`define W1_MON_MASK 10
`define W1_MON_EXPECT 21
// Table word 2 fields
`define W2_SEQ_DELAY 0
`define W2_TMO_DELAY 16

// Fault latch split between the low and high registers
`define FAULT_LO_BITS 8

// Reset values
`define CTRL_RESET 1'b0
`define DRV_SRC_RESET 20'h00000
`define DRV_HOST_RESET 10'h000

// Timing
`define CLK_MHZ 125
`define SEQ_UNIT_NS 10000
`define TMO_UNIT_NS 100000
`define CLK100K_HALF_NS 5000
`define CLK100K_HALF_CYCLES ((`CLK100K_HALF_NS * `CLK_MHZ) / 1000)
`define TMO_PER_SEQ_UNITS (`TMO_UNIT_NS / `SEQ_UNIT_NS)
`define DELAY_MAX_MS 400
`define SEQ_DELAY_MAX ((`DELAY_MAX_MS * 1000000) / `SEQ_UNIT_NS)
`define TMO_DELAY_MAX ((`DELAY_MAX_MS * 1000000) / `TMO_UNIT_NS)
`define FETCH_LIMIT_NS 20000
`define FETCH_LIMIT_CYCLES ((`FETCH_LIMIT_NS * `CLK_MHZ) / 1000)
`define FETCH_CYCLES 16

`endif

// ### rtl/sequencing_state_machine.sv
// Supply sequencing state engine with its AXI4-Lite register file
`timescale 1ns/1ps
`include "seq_engine_regs.svh"
// Overview of operation
// - Table holds 63 state definitions: next states, outputs, timers, latch enable.
// - Every state watches detector outputs of all ten supervised inputs.
// - Any table index may be the next state of any state.
// - Three exits per state: sequence, monitor fault, timeout, each with own target.
// - Sequence and timeout delays are per state, reloaded on entry, up to 400 ms.
// - Each state sets all ten driver levels on entry and holds them.
// - A transition including the definition fetch completes well under 20 us.
// - ADC limit and secondary monitor warnings are ORed into one engine input.
// - Host jump command forces an exit through the sequence route unless a monitor exit fires in the same cycle.
// - Sequence exit fires on selected input at programmed level, optional delay.
// - Delay needs the condition held throughout; any change restarts the timer.
// - Monitor exit is a wide OR of selected inputs departing from expected levels.
// - Monitor exit has no qualifying delay.
// - Timeout exit fires when the state outlasts its timeout, 100 us to 400 ms.
// - Fault latch in two readable registers, one bit per input, set on fault.
// - Fault latching is enabled or disabled per state.
// - Live undervoltage, overvoltage and ADC limit status is read unlatched.
// - Each driver takes engine value, host bit, or internal 100 kHz clock.
module sequencing_state_machine
	import seq_engine_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Supply fault detector outputs, 1 means in tolerance
	input wire logic [9:0] supply_ok,
	input wire logic [9:0] uv_status,
	input wire logic [9:0] ov_status,
	// Warning sources
	input wire logic [11:0] adc_limit,
	input wire logic [4:0] secondary_warn,
	// Programmable driver outputs and engine position
	output logic [9:0] programmable_driver_output,
	output seq_engine_pkg::state_idx_t current_state
);
	import seq_engine_pkg::*;

	typedef struct packed {
		phase_t phase;
		state_idx_t cur;
		state_idx_t tgt;
		logic [4:0] fetch_cnt;
		logic [95:0] def;
		logic [15:0] seq_cnt;
		logic [15:0] tmo_cnt;
		logic seq_cond_prev;
		logic jump_pend;
		logic enable;
		logic [9:0] fault_latch;
		logic [19:0] drv_src;
		logic [9:0] drv_host;
		logic [9:0] drv_out;
		state_idx_t tbl_idx;
		logic aw_full;
		logic [7:0] aw_addr;
		logic w_full;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} sse_state_t;

	sse_state_t st_reg;
	sse_state_t st_next;

	// Definition table; reset clears it like an unprogrammed part
	logic [31:0] tbl_mem [0:`TBL_DEPTH-1];
	logic mem_we;
	logic [7:0] mem_waddr;
	logic [31:0] mem_wdata;

	logic tick_seq;
	logic tick_tmo;
	logic clk_100k;
	logic [9:0] drv_mux;
	logic [9:0] eng_pat;

	time_base u_time_base (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick_seq(tick_seq),
		.tick_tmo(tick_tmo),
		.clk_100k(clk_100k)
	);

	// Per-driver source select
	genvar gi;
	generate
		for (gi = 0; gi < `NUM_INPUTS; gi++) begin : g_drv
			always_comb begin
				case (drv_src_t'(st_reg.drv_src[2*gi +: 2]))
					SRC_ENGINE: drv_mux[gi] = eng_pat[gi];
					SRC_HOST: drv_mux[gi] = st_reg.drv_host[gi];
					SRC_CLOCK: drv_mux[gi] = clk_100k;
					default: drv_mux[gi] = 1'b0;
				endcase
			end
		end
	endgenerate

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = data[8*b +: 8];
			end
		end
		return res;
	endfunction

	// Decoded fields of the active definition
	logic [10:0] engine_in;
	logic warning;
	logic [3:0] seq_sel;
	logic seq_level;
	logic seq_cond;
	logic seq_fire;
	logic mon_fire;
	logic tmo_fire;
	logic [10:0] fault_vec;
	logic [15:0] seq_delay;
	logic [15:0] tmo_delay;
	logic [7:0] tgt_base;
	logic [7:0] cur_base;
	logic [7:0] word_addr;
	logic wr_do;
	logic wr_ok;
	logic [31:0] wr_val;
	logic [9:0] fault_clr;
	logic [31:0] rd_val;
	logic rd_ok;

	always_comb begin
		warning = (|adc_limit) | (|secondary_warn);
		engine_in = {warning, supply_ok};
		seq_sel = st_reg.def[`W0_SEQ_SEL +: 4];
		seq_level = (seq_sel < 4'(`NUM_ENG_IN)) ? engine_in[seq_sel] : 1'b0;
		seq_cond = (seq_sel < 4'(`NUM_ENG_IN)) && (seq_level == st_reg.def[`W0_SEQ_POL]);
		// Delays saturate at the longest programmable duration
		seq_delay = st_reg.def[64 + `W2_SEQ_DELAY +: 16];
		if (seq_delay > 16'(`SEQ_DELAY_MAX)) begin
			seq_delay = 16'(`SEQ_DELAY_MAX);
		end
		tmo_delay = st_reg.def[64 + `W2_TMO_DELAY +: 16];
		if (tmo_delay > 16'(`TMO_DELAY_MAX)) begin
			tmo_delay = 16'(`TMO_DELAY_MAX);
		end
		seq_fire = seq_cond && (st_reg.seq_cnt >= seq_delay);
		// Monitor is combinational: no delay between fault and exit
		fault_vec = st_reg.def[32 + `W1_MON_MASK +: 11]
			& (engine_in ^ st_reg.def[32 + `W1_MON_EXPECT +: 11]);
		mon_fire = |fault_vec;
		tmo_fire = (tmo_delay != 16'h0000) && (st_reg.tmo_cnt >= tmo_delay);
		tgt_base = 8'(st_reg.tgt) * 8'(`NUM_WORDS);
		cur_base = 8'(st_reg.tbl_idx) * 8'(`NUM_WORDS);
		// New pattern leaves together with the new state index
		eng_pat = st_reg.def[32 + `W1_OUT +: 10];
		if (st_reg.phase == PH_FETCH && st_reg.fetch_cnt == 5'(`FETCH_CYCLES - 1)) begin
			eng_pat = tbl_mem[tgt_base + 8'h01][`W1_OUT +: 10];
		end
	end

	// Register write decode
	always_comb begin
		wr_do = st_reg.aw_full && st_reg.w_full && !st_reg.bvalid;
		wr_ok = 1'b1;
		wr_val = 32'h00000000;
		word_addr = cur_base;
		mem_we = 1'b0;
		fault_clr = 10'h000;
		case (st_reg.aw_addr)
			`OFS_TBL_W0: word_addr = cur_base;
			`OFS_TBL_W1: word_addr = cur_base + 8'h01;
			`OFS_TBL_W2: word_addr = cur_base + 8'h02;
			default: word_addr = cur_base;
		endcase
		wr_val = merge(tbl_mem[word_addr], st_reg.w_data, st_reg.w_strb);
		case (st_reg.aw_addr)
			`OFS_CTRL, `OFS_JUMP, `OFS_TBL_INDEX, `OFS_DRV_SRC, `OFS_DRV_HOST: wr_ok = 1'b1;
			`OFS_TBL_W0, `OFS_TBL_W1, `OFS_TBL_W2: begin
				wr_ok = st_reg.tbl_idx < 6'(`NUM_STATES);
				mem_we = wr_do && wr_ok;
			end
			`OFS_FAULT_LO: begin
				if (wr_do && st_reg.w_strb[0]) begin
					fault_clr[`FAULT_LO_BITS-1:0] = st_reg.w_data[`FAULT_LO_BITS-1:0];
				end
			end
			`OFS_FAULT_HI: begin
				if (wr_do && st_reg.w_strb[0]) begin
					fault_clr[9:`FAULT_LO_BITS] = st_reg.w_data[1:0];
				end
			end
			`OFS_ENG_STATUS, `OFS_LIVE_UVOV, `OFS_LIVE_WARN: wr_ok = 1'b0;
			default: wr_ok = 1'b0;
		endcase
		mem_waddr = word_addr;
		mem_wdata = wr_val;
	end

	// Register read decode
	always_comb begin
		rd_ok = 1'b1;
		rd_val = 32'h00000000;
		case (s_axi_araddr)
			`OFS_CTRL: rd_val = {31'h00000000, st_reg.enable};
			`OFS_ENG_STATUS: rd_val = {22'h000000, st_reg.phase, 2'h0, st_reg.cur};
			`OFS_JUMP: rd_val = {31'h00000000, st_reg.jump_pend};
			`OFS_TBL_INDEX: rd_val = {26'h0000000, st_reg.tbl_idx};
			`OFS_TBL_W0: rd_val = tbl_mem[cur_base];
			`OFS_TBL_W1: rd_val = tbl_mem[cur_base + 8'h01];
			`OFS_TBL_W2: rd_val = tbl_mem[cur_base + 8'h02];
			`OFS_FAULT_LO: rd_val = {24'h000000, st_reg.fault_latch[7:0]};
			`OFS_FAULT_HI: rd_val = {30'h00000000, st_reg.fault_latch[9:8]};
			`OFS_LIVE_UVOV: rd_val = {6'h00, ov_status, 6'h00, uv_status};
			`OFS_LIVE_WARN: rd_val = {11'h000, secondary_warn, 4'h0, adc_limit};
			`OFS_DRV_SRC: rd_val = {12'h000, st_reg.drv_src};
			`OFS_DRV_HOST: rd_val = {22'h000000, st_reg.drv_host};
			default: rd_ok = 1'b0;
		endcase
	end

	always_comb begin
		st_next = st_reg;
		// Bus channels
		if (s_axi_awvalid && !st_reg.aw_full) begin
			st_next.aw_full = 1'b1;
			st_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_reg.w_full) begin
			st_next.w_full = 1'b1;
			st_next.w_data = s_axi_wdata;
			st_next.w_strb = s_axi_wstrb;
		end
		if (st_reg.bvalid && s_axi_bready) begin
			st_next.bvalid = 1'b0;
		end
		if (wr_do) begin
			st_next.aw_full = 1'b0;
			st_next.w_full = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
			if (st_reg.w_strb[0]) begin
				case (st_reg.aw_addr)
					`OFS_CTRL: st_next.enable = st_reg.w_data[0];
					`OFS_TBL_INDEX: st_next.tbl_idx = st_reg.w_data[5:0];
					`OFS_DRV_HOST: st_next.drv_host[7:0] = st_reg.w_data[7:0];
					`OFS_DRV_SRC: st_next.drv_src[7:0] = st_reg.w_data[7:0];
					default: st_next.enable = st_reg.enable;
				endcase
			end
			if (st_reg.w_strb[1] && st_reg.aw_addr == `OFS_DRV_HOST) begin
				st_next.drv_host[9:8] = st_reg.w_data[9:8];
			end
			if (st_reg.w_strb[1] && st_reg.aw_addr == `OFS_DRV_SRC) begin
				st_next.drv_src[15:8] = st_reg.w_data[15:8];
			end
			if (st_reg.w_strb[2] && st_reg.aw_addr == `OFS_DRV_SRC) begin
				st_next.drv_src[19:16] = st_reg.w_data[19:16];
			end
		end
		if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !st_reg.rvalid) begin
			st_next.rvalid = 1'b1;
			st_next.rdata = rd_val;
			st_next.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end

		// Sequence qualifying timer
		if (st_reg.phase != PH_RUN || !seq_cond || seq_cond != st_reg.seq_cond_prev) begin
			st_next.seq_cnt = 16'h0000;
		end else if (tick_seq && st_reg.seq_cnt != 16'hFFFF) begin
			st_next.seq_cnt = st_reg.seq_cnt + 16'h0001;
		end
		st_next.seq_cond_prev = seq_cond;
		if (st_reg.phase == PH_RUN && tick_tmo && st_reg.tmo_cnt != 16'hFFFF) begin
			st_next.tmo_cnt = st_reg.tmo_cnt + 16'h0001;
		end

		// Fault latch: new faults win over a clear in the same cycle
		st_next.fault_latch = st_reg.fault_latch & ~fault_clr;
		if (st_reg.phase == PH_RUN && st_reg.def[`W0_LATCH_EN]) begin
			st_next.fault_latch = st_next.fault_latch | fault_vec[9:0];
		end

		// Jump request; a repeated write while pending is harmless
		if (wr_do && st_reg.aw_addr == `OFS_JUMP && st_reg.w_strb[0] && st_reg.w_data[0]) begin
			st_next.jump_pend = 1'b1;
		end

		case (st_reg.phase)
			PH_IDLE: begin
				st_next.drv_out = 10'h000;
				if (st_reg.enable) begin
					st_next.tgt = 6'h00;
					st_next.fetch_cnt = 5'h00;
					st_next.phase = PH_FETCH;
				end
			end
			PH_FETCH: begin
				// Outputs of the state being left stay until the new one is loaded
				if (st_reg.fetch_cnt == 5'(`FETCH_CYCLES - 1)) begin
					st_next.def = {tbl_mem[tgt_base + 8'h02], tbl_mem[tgt_base + 8'h01],
						tbl_mem[tgt_base]};
					st_next.cur = st_reg.tgt;
					st_next.seq_cnt = 16'h0000;
					st_next.tmo_cnt = 16'h0000;
					st_next.phase = PH_RUN;
				end else begin
					st_next.fetch_cnt = st_reg.fetch_cnt + 5'h01;
				end
			end
			PH_RUN: begin
				st_next.fetch_cnt = 5'h00;
				if (mon_fire) begin
					st_next.tgt = st_reg.def[`W0_MON_NEXT +: 6];
					st_next.phase = PH_FETCH;
				end else if (seq_fire || st_reg.jump_pend) begin
					st_next.tgt = st_reg.def[`W0_SEQ_NEXT +: 6];
					st_next.phase = PH_FETCH;
				end else if (tmo_fire) begin
					st_next.tgt = st_reg.def[`W0_TMO_NEXT +: 6];
					st_next.phase = PH_FETCH;
				end
				// Unused top index falls back to the first entry
				if (st_next.tgt == 6'h3F) begin
					st_next.tgt = 6'h00;
				end
				if (st_next.phase == PH_FETCH) begin
					st_next.jump_pend = 1'b0;
				end
			end
			default: st_next.phase = PH_IDLE;
		endcase
		if (st_reg.phase != PH_IDLE) begin
			st_next.drv_out = drv_mux;
		end
		if (!st_reg.enable) begin
			st_next.phase = PH_IDLE;
			st_next.drv_out = drv_mux & ~engine_mask(st_reg.drv_src);
		end
	end

	// Engine-sourced drivers read low while the engine is stopped
	function automatic logic [9:0] engine_mask(input logic [19:0] src);
		logic [9:0] m;
		m = 10'h000;
		for (int i = 0; i < 10; i++) begin
			m[i] = (src[2*i +: 2] == SRC_ENGINE);
		end
		return m;
	endfunction

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
			st_reg.phase <= PH_IDLE;
			st_reg.enable <= `CTRL_RESET;
			st_reg.drv_src <= `DRV_SRC_RESET;
			st_reg.drv_host <= `DRV_HOST_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < `TBL_DEPTH; i++) begin
				tbl_mem[i] <= 32'h00000000;
			end
		end else if (mem_we) begin
			tbl_mem[mem_waddr] <= mem_wdata;
		end
	end

	assign s_axi_awready = !st_reg.aw_full;
	assign s_axi_wready = !st_reg.w_full;
	assign s_axi_bvalid = st_reg.bvalid;
	assign s_axi_bresp = st_reg.bresp;
	assign s_axi_arready = !st_reg.rvalid;
	assign s_axi_rvalid = st_reg.rvalid;
	assign s_axi_rdata = st_reg.rdata;
	assign s_axi_rresp = st_reg.rresp;
	assign programmable_driver_output = st_reg.drv_out;
	assign current_state = st_reg.cur;
endmodule // sequencing_state_machine

// ### rtl/time_base.sv
// Time base: 10 us and 100 us ticks and the free 100 kHz clock
`timescale 1ns/1ps
`include "seq_engine_regs.svh"
module time_base (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Timing outputs
	output logic tick_seq,
	output logic tick_tmo,
	output logic clk_100k
);
	import seq_engine_pkg::*;

	typedef struct packed {
		logic [9:0] half_cnt;
		logic clk;
		logic [3:0] unit_cnt;
		logic tick_seq;
		logic tick_tmo;
	} tb_state_t;

	tb_state_t st_reg;
	tb_state_t st_next;

	localparam logic [9:0] HALF_LAST = 10'(`CLK100K_HALF_CYCLES - 1);
	localparam logic [3:0] UNIT_LAST = 4'(`TMO_PER_SEQ_UNITS - 1);

	always_comb begin
		st_next = st_reg;
		st_next.tick_seq = 1'b0;
		st_next.tick_tmo = 1'b0;
		if (st_reg.half_cnt == HALF_LAST) begin
			st_next.half_cnt = 10'h000;
			st_next.clk = ~st_reg.clk;
			// One full clock period is one sequence delay unit
			if (st_reg.clk) begin
				st_next.tick_seq = 1'b1;
				if (st_reg.unit_cnt == UNIT_LAST) begin
					st_next.unit_cnt = 4'h0;
					st_next.tick_tmo = 1'b1;
				end else begin
					st_next.unit_cnt = st_reg.unit_cnt + 4'h1;
				end
			end
		end else begin
			st_next.half_cnt = st_reg.half_cnt + 10'h001;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tick_seq = st_reg.tick_seq;
	assign tick_tmo = st_reg.tick_tmo;
	assign clk_100k = st_reg.clk;
endmodule // time_base

// ### tb/seq_engine_asserts.sv
// Bus handshake and engine timing checks for the sequencing engine
`timescale 1ns/1ps
module seq_engine_asserts
	import seq_engine_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bus handshakes
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Engine position
	input wire seq_engine_pkg::state_idx_t current_state
);
	import seq_engine_pkg::*;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	state_idx_t prev_reg;
	logic [4:0] gap_reg;
	// Cycles since the last state change, saturating
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev_reg <= 6'h00;
			gap_reg <= 5'h00;
		end else begin
			prev_reg <= current_state;
			if (current_state != prev_reg) gap_reg <= 5'h00;
			else if (gap_reg != 5'h1F) gap_reg <= gap_reg + 5'h01;
		end
	end
	sequence s_ar_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_r_waiting;
		s_axi_rvalid && !s_axi_rready;
	endsequence
	property p_ar_answer;
		s_ar_taken |=> s_axi_rvalid;
	endproperty
	property p_r_hold;
		s_r_waiting |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
	endproperty
	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	property p_b_after_both;
		$rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready);
	endproperty
	property p_resp_code;
		s_axi_rvalid |-> s_axi_rresp == RESP_OKAY || s_axi_rresp == RESP_SLVERR;
	endproperty
	property p_err_zero;
		s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000;
	endproperty
	property p_state_range;
		current_state != 6'h3F;
	endproperty
	property p_fetch_gap;
		current_state != prev_reg |-> gap_reg >= 5'h10;
	endproperty
	a_ar_answer: assert property (p_ar_answer) else $error("read not answered");
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped early");
	a_ar_block: assert property (p_ar_block) else $error("read taken while answer open");
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
	a_b_after_both: assert property (p_b_after_both) else $error("write answered too soon");
	a_resp_code: assert property (p_resp_code) else $error("bad read response code");
	a_err_zero: assert property (p_err_zero) else $error("error read carries data");
	a_state_range: assert property (p_state_range) else $error("state index out of range");
	a_fetch_gap: assert property (p_fetch_gap) else $error("state changed inside fetch");
endmodule // seq_engine_asserts

bind sequencing_state_machine seq_engine_asserts u_asserts (.aclk, .aresetn, .s_axi_awready,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .current_state);

// ### tb/supply_model.sv
// Behavioural supply detectors and warning sources facing the engine
`timescale 1ns/1ps
module supply_model (
	// Commanded rail conditions
	input wire logic [9:0] ok_cmd,
	input wire logic [9:0] uv_cmd,
	input wire logic [9:0] ov_cmd,
	input wire logic [11:0] adc_cmd,
	input wire logic [4:0] sec_cmd,
	// Detector outputs
	output logic [9:0] supply_ok,
	output logic [9:0] uv_status,
	output logic [9:0] ov_status,
	output logic [11:0] adc_limit,
	output logic [4:0] secondary_warn
);
	// Comparators are treated as ideal, no filtering
	assign supply_ok = ok_cmd;
	assign uv_status = uv_cmd;
	assign ov_status = ov_cmd;
	assign adc_limit = adc_cmd;
	assign secondary_warn = sec_cmd;
endmodule // supply_model

// ### tb/tb_supply_sequencing_state_engine.sv
// Self-checking bench for the supply sequencing engine
`timescale 1ns/1ps
`include "seq_engine_regs.svh"
`define CHK(nm, ex, got) begin \
	comparisons++; \
	if ((got) !== (ex)) begin \
		err_total++; \
		$display("MISMATCH %s expected %0h seen %0h", nm, ex, got); \
	end \
end
module tb_supply_sequencing_state_engine;
	import seq_engine_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b1;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b1;
	logic [9:0] supply_ok, uv_status, ov_status, programmable_driver_output;
	logic [11:0] adc_limit;
	logic [4:0] secondary_warn;
	state_idx_t current_state;
	logic [9:0] ok_cmd = 10'h000, uv_cmd = 10'h000, ov_cmd = 10'h000;
	logic [11:0] adc_cmd = 12'h000;
	logic [4:0] sec_cmd = 5'h00;
	// Seed 81578
	logic [16:0] rnd = 17'h13EAA;
	logic [31:0] m_w0 [64];
	logic [31:0] m_w1 [64];
	int err_total = 0;
	int comparisons = 0;
	int cycles = 0;
	logic clk_seen;

	sequencing_state_machine u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .supply_ok, .uv_status, .ov_status, .adc_limit,
		.secondary_warn, .programmable_driver_output, .current_state);
	supply_model u_supply (.ok_cmd, .uv_cmd, .ov_cmd, .adc_cmd, .sec_cmd, .supply_ok,
		.uv_status, .ov_status, .adc_limit, .secondary_warn);

	initial begin
		forever #4 aclk = ~aclk;
	end

	function automatic logic [16:0] lfsr(input logic [16:0] v);
		return {v[15:0], v[16] ^ v[13]};
	endfunction

	task automatic results();
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Ceiling well above the longest timer wait in the run
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 40000) begin
			err_total++;
			results();
		end
	end

	// Ready lines stay high, so no request is ever stalled by the bench
	task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic done;
		done = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				done = 1'b1;
				`CHK("bresp", er, s_axi_bresp)
			end
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
		logic done;
		done = 1'b0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				done = 1'b1;
				`CHK("rresp", er, s_axi_rresp)
				`CHK("rdata", ex, s_axi_rdata)
			end
		end
	endtask

	task automatic prog(input int i, input logic [31:0] w0, input logic [31:0] w1,
		input logic [31:0] w2);
		rnd = lfsr(rnd);
		m_w0[i] = w0;
		m_w1[i] = w1 | {22'h000000, rnd[9:0]};
		wr_chk(`OFS_TBL_INDEX, 32'(i), RESP_OKAY);
		wr_chk(`OFS_TBL_W0, w0, RESP_OKAY);
		wr_chk(`OFS_TBL_W1, m_w1[i], RESP_OKAY);
		wr_chk(`OFS_TBL_W2, w2, RESP_OKAY);
	endtask

	task automatic go(input int s, input int lim);
		int n;
		n = 0;
		while (current_state !== 6'(s) && n < lim) begin
			@(posedge aclk);
			n++;
		end
		`CHK("state", 6'(s), current_state)
		`CHK("drivers", m_w1[s][9:0], programmable_driver_output)
	endtask

	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd_chk(`OFS_CTRL, 32'h0000_0000, RESP_OKAY);
		rd_chk(`OFS_DRV_SRC, 32'h0000_0000, RESP_OKAY);
		rd_chk(8'hFC, 32'h0000_0000, RESP_SLVERR);
		wr_chk(`OFS_ENG_STATUS, 32'h0000_0001, RESP_SLVERR);
		wr_chk(`OFS_TBL_INDEX, 32'h0000_003F, RESP_OKAY);
		wr_chk(`OFS_TBL_W0, 32'h0000_0001, RESP_SLVERR);
		for (int i = 0; i < 2; i++) begin
			rnd = lfsr(rnd);
			uv_cmd <= rnd[9:0];
			ov_cmd <= rnd[16:7];
			@(posedge aclk);
			rd_chk(`OFS_LIVE_UVOV, {6'h00, rnd[16:7], 6'h00, rnd[9:0]}, RESP_OKAY);
		end
		prog(0, 32'h0202_0905, 32'h0000_0000, 32'h0000_0000);
		prog(5, 32'hF102_0709, 32'h0040_0800, 32'h0000_0000);
		prog(9, 32'hA302_070C, 32'h0040_0800, 32'h0000_0003);
		prog(12, 32'h0114_0728, 32'h0040_0800, 32'h0001_0000);
		prog(7, 32'hF021_0000, 32'h0000_0000, 32'h0001_0000);
		prog(33, 32'hF000_0000, 32'h0000_0000, 32'h0000_0000);
		wr_chk(`OFS_CTRL, 32'h0000_0001, RESP_OKAY);
		repeat (20) @(posedge aclk);
		go(0, 1);
		ok_cmd <= 10'h3FF;
		go(5, 40);
		wr_chk(`OFS_JUMP, 32'h0000_0001, RESP_OKAY);
		go(9, 40);
		// A one-cycle drop of the warning must restart the delay
		adc_cmd <= 12'h004;
		repeat (2000) @(posedge aclk);
		adc_cmd <= 12'h000;
		@(posedge aclk);
		adc_cmd <= 12'h004;
		repeat (2000) @(posedge aclk);
		`CHK("held", 6'h09, current_state)
		go(12, 4000);
		adc_cmd <= 12'h000;
		ok_cmd <= 10'h3FC;
		go(7, 40);
		rd_chk(`OFS_FAULT_LO, 32'h0000_0002, RESP_OKAY);
		rd_chk(`OFS_FAULT_HI, 32'h0000_0000, RESP_OKAY);
		wr_chk(`OFS_FAULT_LO, 32'h0000_0002, RESP_OKAY);
		rd_chk(`OFS_FAULT_LO, 32'h0000_0000, RESP_OKAY);
		// Timeout ticks run free, so one unit may take a full 100 us
		go(33, 13000);
		wr_chk(`OFS_DRV_SRC, 32'h0000_000D, RESP_OKAY);
		wr_chk(`OFS_DRV_HOST, 32'h0000_0001, RESP_OKAY);
		repeat (2) @(posedge aclk);
		`CHK("host drv", {m_w1[33][9:2], 2'b01}, programmable_driver_output)
		wr_chk(`OFS_DRV_SRC, 32'h0000_002D, RESP_OKAY);
		repeat (2) @(posedge aclk);
		clk_seen = programmable_driver_output[2];
		repeat (`CLK100K_HALF_CYCLES) @(posedge aclk);
		`CHK("clock drv", ~clk_seen, programmable_driver_output[2])
		results();
	end
endmodule // tb_supply_sequencing_state_engine
